//--- core/bpsc_pkg.sv
package bpsc_pkg;

    localparam int          NPORTS           = 3;

    // register map, one block of four words per bridge function
    localparam logic [5:0]  OFF_POWER_CTRL_STATUS_REG        = 6'h00;
    localparam logic [5:0]  OFF_CFG          = 6'h04;
    localparam logic [5:0]  OFF_TIMER        = 6'h08;
    localparam logic [5:0]  OFF_STAT         = 6'h0C;
    localparam logic [5:0]  OFF_WAKE_CTRL    = 6'h30;

    // field positions
    localparam int          POWER_CTRL_STATUS_REG_KEEP_BIT   = 3;
    localparam int          POWER_CTRL_STATUS_REG_PME_EN_BIT = 8;
    localparam int          POWER_CTRL_STATUS_REG_POWER_EVENT_STATUS_BIT_BIT   = 15;
    localparam int          WAKE_EN_BIT      = 0;
    localparam int          BEACON_EN_BIT    = 1;
    localparam int          CFG_DONE_BIT     = 0;

    // power-state field encodings
    localparam logic [1:0]  PS_FIELD_D0      = 2'h0;
    localparam logic [1:0]  PS_FIELD_D3      = 2'h3;

    // values after reset
    localparam logic [15:0] TIMEOUT_RST      = 16'h0010;
    localparam logic        KEEP_RST         = 1'b1;
    localparam logic        WAKE_EN_RST      = 1'b1;
    localparam logic        BEACON_EN_RST    = 1'b1;

    // timer tick
    localparam int          CLK_PERIOD_PS    = 4000;
    localparam int          TICK_NS          = 1000;
    localparam int          TICK_CYCLES_RAW  = (TICK_NS * 1000) / CLK_PERIOD_PS;
    localparam int          TICK_CYCLES      = (TICK_CYCLES_RAW < 1) ? 1 : TICK_CYCLES_RAW;
    localparam logic [9:0]  TICK_LAST        = 10'(TICK_CYCLES - 1);

    localparam logic [1:0]  RESP_OKAY        = 2'h0;
    localparam logic [1:0]  RESP_SLVERR      = 2'h2;

    typedef enum logic [1:0] {PS_D0U, PS_D0A, PS_D3H, PS_D3C} bpsc_pstate_t;
    typedef enum logic [2:0] {K_CFG0, K_MSG, K_REQ, K_CPL_OWN, K_CPL_THRU} bpsc_kind_t;
    typedef enum logic [1:0] {DISP_ACCEPT, DISP_UR, DISP_UC, DISP_ROUTE} bpsc_disp_t;

endpackage : bpsc_pkg

//--- core/bpsc_top.sv
`timescale 1ns/1ps

// Overview of operation
// - four states: D0 uninit, D0 active, D3hot, D3cold
// - downstream state affects only its own port
// - port 0 D3hot governs whole device
// - D3hot lets that link enter L1
// - keep-context set retains state across D3hot
// - L2/L3 Ready resets device regardless of keep-context
// - D0 uninit to D0 active once configured
// - D0 active to D3hot on D3 write
// - D3hot to D0 uninit on D0 write
// - D3cold returns to D0 uninit via reset
// - D3hot still completes type 0 config requests
// - D3hot still accepts messages targeting bridge
// - other primary requests in D3hot are UR
// - TLP-caused errors reported as normal in D3hot
// - non-TLP errors send no message in D3hot
// - completions to bridge in D3hot are unexpected
// - pass-through completions routed as in D0
// - secondary-side requests in D3hot are UR
// - downstream ports send power events in D3hot
// - resend power event on service timeout
// - uncleared status at deep sleep wakes link
// - transmit beacon, drive wake, never detect beacon
// - power-event status survives reset, sticky
// - turn-off blocks power events until link returns
module bpsc_top
    import bpsc_pkg::*;
(
    // clock and resets
    input  wire logic                     sys_clk,
    input  wire logic                     rstn,
    input  wire logic                     aux_rstn,
    // axi4-lite register slave
    input  wire logic [11:0]              s_axi_awaddr,
    input  wire logic                     s_axi_awvalid,
    output logic                          s_axi_awready,
    input  wire logic [31:0]              s_axi_wdata,
    input  wire logic [3:0]               s_axi_wstrb,
    input  wire logic                     s_axi_wvalid,
    output logic                          s_axi_wready,
    output logic [1:0]                    s_axi_bresp,
    output logic                          s_axi_bvalid,
    input  wire logic                     s_axi_bready,
    input  wire logic [11:0]              s_axi_araddr,
    input  wire logic                     s_axi_arvalid,
    output logic                          s_axi_arready,
    output logic [31:0]                   s_axi_rdata,
    output logic [1:0]                    s_axi_rresp,
    output logic                          s_axi_rvalid,
    input  wire logic                     s_axi_rready,
    // link and power events
    input  wire logic                     l23_ready,
    input  wire logic                     turnoff_rx,
    input  wire logic                     link_l0_return,
    input  wire logic                     pwr_removed,
    input  wire logic [NPORTS-1:0]        hp_event,
    output logic [NPORTS-1:0]             pme_tx,
    // request classification
    input  wire logic                     tlp_valid,
    input  wire logic [1:0]               tlp_port,
    input  wire bpsc_kind_t               tlp_kind,
    input  wire logic                     tlp_secondary,
    output logic                          disp_valid,
    output logic [1:0]                    disp_port,
    output bpsc_disp_t                    disp_code,
    // error reporting
    input  wire logic                     err_valid,
    input  wire logic [1:0]               err_port,
    input  wire logic                     err_from_tlp,
    output logic                          err_msg_valid,
    output logic [1:0]                    err_msg_port,
    // state and wakeup
    output logic [NPORTS-1:0][1:0]        power_state_field,
    output logic [NPORTS-1:0]             l1_permit,
    output logic                          sideband_wake_o,
    output logic                          sideband_wake_oe,
    output logic                          beacon_tx
);

    typedef struct packed {
        bpsc_pstate_t [NPORTS-1:0] ps;
        logic [NPORTS-1:0]         keep;
        logic [NPORTS-1:0]         pme_en;
        logic [NPORTS-1:0]         power_event_status_bit;
        logic [NPORTS-1:0]         configured;
        logic [NPORTS-1:0][15:0]   tmo;
        logic [NPORTS-1:0][15:0]   tmr;
        logic [NPORTS-1:0]         tmr_run;
        logic [NPORTS-1:0]         due;
        logic [NPORTS-1:0]         pme_tx;
        logic [9:0]                tick_cnt;
        logic                      tick;
        logic                      blk;
        logic                      wake_en;
        logic                      beacon_en;
        logic                      wake_act;
        logic                      aw_have;
        logic [11:0]               aw_addr;
        logic                      w_have;
        logic [31:0]               wdata;
        logic [3:0]                wstrb;
        logic                      bvalid;
        logic [1:0]                bresp;
        logic                      rvalid;
        logic [31:0]               rdata;
        logic [1:0]                rresp;
        logic                      disp_valid;
        logic [1:0]                disp_port;
        bpsc_disp_t                disp_code;
        logic                      err_msg_valid;
        logic [1:0]                err_msg_port;
    } bpsc_state_t;

    bpsc_state_t        s_q;
    bpsc_state_t        s_d;
    logic [NPORTS-1:0]  d3eff;
    logic               wr_do;
    logic               wr_hit;
    logic [1:0]         wr_port;
    logic [5:0]         wr_off;
    logic [31:0]        rd_word;

    function automatic logic addr_hit(input logic [11:0] a);
        addr_hit = (a[11:6] == 6'h00) && (a[1:0] == 2'h0)
                   && ((a[5:4] != 2'h3) || (a[5:0] == OFF_WAKE_CTRL));
    endfunction : addr_hit

    function automatic logic [5:0] addr_off(input logic [11:0] a);
        addr_off = (a[5:0] == OFF_WAKE_CTRL) ? OFF_WAKE_CTRL : {2'h0, a[3:0]};
    endfunction : addr_off

    function automatic logic [1:0] ps_field(input bpsc_pstate_t ps);
        ps_field = ((ps == PS_D3H) || (ps == PS_D3C)) ? PS_FIELD_D3 : PS_FIELD_D0;
    endfunction : ps_field

    function automatic bpsc_disp_t classify(input logic d3, input bpsc_kind_t k, input logic sec);
        if (k == K_CPL_THRU)
            classify = DISP_ROUTE;
        else if (!d3)
            classify = DISP_ACCEPT;
        else if (k == K_CPL_OWN)
            classify = DISP_UC;
        else if (sec)
            classify = DISP_UR;
        else if ((k == K_CFG0) || (k == K_MSG))
            classify = DISP_ACCEPT;
        else
            classify = DISP_UR;
    endfunction : classify

    // a downstream port follows its own state, upstream D3hot also counts for all in d3eff and l1_permit
    for (genvar g = 0; g < NPORTS; g++)
    begin : g_port
        assign d3eff[g]             = (s_q.ps[g] == PS_D3H) || (s_q.ps[0] == PS_D3H);
        assign l1_permit[g]         = d3eff[g];
        assign power_state_field[g] = ps_field(s_q.ps[g]);
    end

    assign wr_do   = s_q.aw_have && s_q.w_have && !s_q.bvalid;
    assign wr_hit  = addr_hit(s_q.aw_addr);
    assign wr_port = s_q.aw_addr[5:4];
    assign wr_off  = addr_off(s_q.aw_addr);

    always_comb
    begin
        logic [1:0] rp;
        logic [5:0] ro;
        rp      = s_axi_araddr[5:4];
        ro      = addr_off(s_axi_araddr);
        rd_word = 32'h0000_0000;
        if (ro == OFF_WAKE_CTRL)
            rd_word = {30'h0, s_q.beacon_en, s_q.wake_en};
        else if (ro == OFF_POWER_CTRL_STATUS_REG)
            rd_word = {16'h0, s_q.power_event_status_bit[rp], 6'h00, s_q.pme_en[rp], 4'h0, s_q.keep[rp], 1'b0, ps_field(s_q.ps[rp])};
        else if (ro == OFF_CFG)
            rd_word = {31'h0, s_q.configured[rp]};
        else if (ro == OFF_TIMER)
            rd_word = {16'h0, s_q.tmo[rp]};
        else if (ro == OFF_STAT)
            rd_word = {27'h0, s_q.due[rp], s_q.tmr_run[rp], d3eff[rp], 2'(s_q.ps[rp])};
    end

    always_comb
    begin
        logic pw;
        logic pm_lo;
        logic pm_hi;
        pw    = 1'b0;
        pm_lo = 1'b0;
        pm_hi = 1'b0;
        s_d   = s_q;
        s_d.pme_tx = '0;

        // fixed service-timer tick, avoids a wide per-port prescaler
        s_d.tick = (s_q.tick_cnt == TICK_LAST);
        s_d.tick_cnt = s_d.tick ? 10'h000 : s_q.tick_cnt + 10'h001;

        // write channel: address and data taken in either order
        if (s_q.bvalid && s_axi_bready)
            s_d.bvalid = 1'b0;
        if (s_axi_awvalid && s_axi_awready)
        begin
            s_d.aw_have = 1'b1;
            s_d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            s_d.w_have = 1'b1;
            s_d.wdata  = s_axi_wdata;
            s_d.wstrb  = s_axi_wstrb;
        end
        if (wr_do)
        begin
            s_d.aw_have = 1'b0;
            s_d.w_have  = 1'b0;
            s_d.bvalid  = 1'b1;
            s_d.bresp   = wr_hit ? RESP_OKAY : RESP_SLVERR;
        end
        if (wr_do && wr_hit && (wr_off == OFF_WAKE_CTRL) && s_q.wstrb[0])
        begin
            s_d.wake_en   = s_q.wdata[WAKE_EN_BIT];
            s_d.beacon_en = s_q.wdata[BEACON_EN_BIT];
        end

        // read channel
        if (s_q.rvalid && s_axi_rready)
            s_d.rvalid = 1'b0;
        if (s_axi_arvalid && s_axi_arready)
        begin
            s_d.rvalid = 1'b1;
            s_d.rdata  = addr_hit(s_axi_araddr) ? rd_word : 32'h0000_0000;
            s_d.rresp  = addr_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end

        for (int p = 0; p < NPORTS; p++)
        begin
            pw    = wr_do && wr_hit && (wr_port == 2'(p)) && (wr_off != OFF_WAKE_CTRL);
            pm_lo = pw && (wr_off == OFF_POWER_CTRL_STATUS_REG) && s_q.wstrb[0];
            pm_hi = pw && (wr_off == OFF_POWER_CTRL_STATUS_REG) && s_q.wstrb[1];
            if (pm_lo)
                s_d.keep[p] = s_q.wdata[POWER_CTRL_STATUS_REG_KEEP_BIT];
            if (pm_hi)
                s_d.pme_en[p] = s_q.wdata[POWER_CTRL_STATUS_REG_PME_EN_BIT];
            if (pw && (wr_off == OFF_CFG) && s_q.wstrb[0] && s_q.wdata[CFG_DONE_BIT])
                s_d.configured[p] = 1'b1;
            if (pw && (wr_off == OFF_TIMER) && s_q.wstrb[0])
                s_d.tmo[p][7:0] = s_q.wdata[7:0];
            if (pw && (wr_off == OFF_TIMER) && s_q.wstrb[1])
                s_d.tmo[p][15:8] = s_q.wdata[15:8];

            unique case (s_q.ps[p])
                PS_D0U:
                    if (s_q.configured[p])
                        s_d.ps[p] = PS_D0A;
                PS_D0A:
                    if (pm_lo && (s_q.wdata[1:0] == PS_FIELD_D3))
                        s_d.ps[p] = PS_D3H;
                PS_D3H:
                    if (pwr_removed)
                        s_d.ps[p] = PS_D3C;
                    else if (pm_lo && (s_q.wdata[1:0] == PS_FIELD_D0))
                    begin
                        s_d.ps[p]         = PS_D0U;
                        s_d.configured[p] = 1'b0;
                        // context is lost only when software asked for it
                        if (!s_q.keep[p])
                        begin
                            s_d.tmo[p]    = TIMEOUT_RST;
                            s_d.pme_en[p] = 1'b0;
                        end
                    end
                PS_D3C:
                    s_d.ps[p] = PS_D3C;
            endcase

            if (p != 0)
            begin
                if (s_q.tmr_run[p] && s_q.tick)
                begin
                    if ((17'(s_q.tmr[p]) + 17'h00001) >= {1'b0, s_q.tmo[p]})
                    begin
                        s_d.due[p]     = 1'b1;
                        s_d.tmr_run[p] = 1'b0;
                        s_d.tmr[p]     = 16'h0000;
                    end
                    else
                        s_d.tmr[p] = s_q.tmr[p] + 16'h0001;
                end
                // a due message waits out the turn-off block, never dropped
                // a turn-off in this cycle already holds the message back
                if (s_q.due[p] && !s_q.blk && !turnoff_rx)
                begin
                    s_d.pme_tx[p]  = 1'b1;
                    s_d.due[p]     = 1'b0;
                    s_d.tmr_run[p] = 1'b1;
                    s_d.tmr[p]     = 16'h0000;
                end
                if (pm_hi && s_q.wdata[POWER_CTRL_STATUS_REG_POWER_EVENT_STATUS_BIT_BIT])
                begin
                    s_d.power_event_status_bit[p]    = 1'b0;
                    s_d.tmr_run[p] = 1'b0;
                    s_d.due[p]     = 1'b0;
                end
                // set placed last so an event beats a same-cycle clear
                if (hp_event[p] && d3eff[p] && s_q.pme_en[p])
                begin
                    s_d.power_event_status_bit[p] = 1'b1;
                    s_d.due[p]  = 1'b1;
                end
            end
        end

        if (turnoff_rx)
            s_d.blk = 1'b1;
        else if (link_l0_return)
            s_d.blk = 1'b0;

        // only transmit sides exist; incoming beacon is never looked at
        s_d.wake_act = l23_ready && (|s_q.power_event_status_bit[NPORTS-1:1]);

        s_d.disp_valid    = tlp_valid;
        s_d.disp_port     = tlp_port;
        s_d.disp_code     = classify(d3eff[tlp_port], tlp_kind, tlp_secondary);
        s_d.err_msg_valid = err_valid && (err_from_tlp || !d3eff[err_port]);
        s_d.err_msg_port  = err_port;

        // entering L2/L3 Ready drops the function context; bus state kept
        if (l23_ready || !rstn)
        begin
            for (int p = 0; p < NPORTS; p++)
            begin
                s_d.ps[p] = PS_D0U;
            end
            s_d.keep       = {NPORTS{KEEP_RST}};
            s_d.pme_en     = '0;
            s_d.configured = '0;
            s_d.tmo        = {NPORTS{TIMEOUT_RST}};
            s_d.tmr        = '0;
            s_d.tmr_run    = '0;
            s_d.due        = '0;
            s_d.pme_tx     = '0;
            s_d.blk        = 1'b0;
        end
        if (!rstn)
        begin
            s_d.tick_cnt      = 10'h000;
            s_d.tick          = 1'b0;
            s_d.wake_en       = WAKE_EN_RST;
            s_d.beacon_en     = BEACON_EN_RST;
            s_d.wake_act      = 1'b0;
            s_d.aw_have       = 1'b0;
            s_d.aw_addr       = 12'h000;
            s_d.w_have        = 1'b0;
            s_d.wdata         = 32'h0000_0000;
            s_d.wstrb         = 4'h0;
            s_d.bvalid        = 1'b0;
            s_d.bresp         = RESP_OKAY;
            s_d.rvalid        = 1'b0;
            s_d.rdata         = 32'h0000_0000;
            s_d.rresp         = RESP_OKAY;
            s_d.disp_valid    = 1'b0;
            s_d.disp_port     = 2'h0;
            s_d.disp_code     = DISP_ACCEPT;
            s_d.err_msg_valid = 1'b0;
            s_d.err_msg_port  = 2'h0;
        end
        // status is power-event context: of the resets, only the aux reset clears it
        if (!aux_rstn)
            s_d.power_event_status_bit = '0;
    end

    always_ff @(posedge sys_clk)
    begin
        s_q <= s_d;
    end

    assign s_axi_awready    = !s_q.aw_have && !s_q.bvalid;
    assign s_axi_wready     = !s_q.w_have && !s_q.bvalid;
    assign s_axi_bvalid     = s_q.bvalid;
    assign s_axi_bresp      = s_q.bresp;
    assign s_axi_arready    = !s_q.rvalid;
    assign s_axi_rvalid     = s_q.rvalid;
    assign s_axi_rdata      = s_q.rdata;
    assign s_axi_rresp      = s_q.rresp;
    assign pme_tx           = s_q.pme_tx;
    assign disp_valid       = s_q.disp_valid;
    assign disp_port        = s_q.disp_port;
    assign disp_code        = s_q.disp_code;
    assign err_msg_valid    = s_q.err_msg_valid;
    assign err_msg_port     = s_q.err_msg_port;
    assign sideband_wake_o  = 1'b0;
    assign sideband_wake_oe = s_q.wake_act && s_q.wake_en;
    assign beacon_tx        = s_q.wake_act && s_q.beacon_en;

    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    logic pm0_lo;
    assign pm0_lo = wr_do && wr_hit && (wr_port == 2'h0) && (wr_off == OFF_POWER_CTRL_STATUS_REG) && s_q.wstrb[0] && !l23_ready;

    AST_D3_ENTRY: assert property (pm0_lo && (s_q.ps[0] == PS_D0A) && (s_q.wdata[1:0] == PS_FIELD_D3)
        |=> (s_q.ps[0] == PS_D3H) && (l1_permit == {NPORTS{1'b1}}))
        else $error("port 0 did not enter D3hot");
    AST_D0_RETURN: assert property (pm0_lo && (s_q.ps[0] == PS_D3H) && !pwr_removed
        && (s_q.wdata[1:0] == PS_FIELD_D0) |=> (s_q.ps[0] == PS_D0U) && (power_state_field[0] == PS_FIELD_D0))
        else $error("port 0 did not return to D0 uninit");
    AST_CFG_ACTIVE: assert property ((s_q.ps[1] == PS_D0U) && s_q.configured[1] && !l23_ready
        |=> s_q.ps[1] == PS_D0A)
        else $error("configured port stayed uninitialised");
    AST_SEC_UR: assert property (tlp_valid && tlp_secondary && d3eff[tlp_port] && (tlp_kind == K_REQ)
        |=> disp_valid && (disp_code == DISP_UR) && (disp_port == $past(tlp_port)))
        else $error("secondary request in D3hot not UR");
    AST_OWN_UC: assert property (tlp_valid && d3eff[tlp_port] && (tlp_kind == K_CPL_OWN)
        |=> disp_code == DISP_UC)
        else $error("own completion in D3hot not UC");
    AST_THRU_ROUTE: assert property (tlp_valid && (tlp_kind == K_CPL_THRU) |=> disp_code == DISP_ROUTE)
        else $error("pass-through completion not routed");
    AST_ERR_DROP: assert property (err_valid && !err_from_tlp && d3eff[err_port] |=> !err_msg_valid)
        else $error("non-TLP error reported in D3hot");
    AST_WAKE: assert property (l23_ready && s_q.power_event_status_bit[1] && s_q.wake_en && !wr_do
        |=> sideband_wake_oe)
        else $error("wake not driven at deep sleep");
    AST_PME_BLOCK: assert property (s_q.blk |-> pme_tx == '0)
        else $error("power event sent while blocked");

endmodule : bpsc_top

//--- verif/bpsc_root_model.sv
`timescale 1ns/1ps
module bpsc_root_model
    import bpsc_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    // wake wire and power events
    input  wire logic        sideband_wake_oe,
    input  wire logic [2:0]  pme_tx,
    output logic             wake_level,
    output logic [7:0]       pme_count_q
);
    // pulled up, so a released wire reads high
    assign wake_level = !sideband_wake_oe;
    always_ff @(posedge sys_clk)
        if (!rstn)
            pme_count_q <= 8'h00;
        else
            pme_count_q <= pme_count_q + 8'(|pme_tx);
endmodule : bpsc_root_model

//--- verif/bpsc_top_bench.sv
`timescale 1ns/1ps
module bpsc_top_bench
    import bpsc_pkg::*;
;
    logic            sys_clk = 1'h0, rstn = 1'h0, aux_rstn = 1'h0, pwr_removed = 1'h0, l23_ready = 1'h0;
    logic            turnoff_rx = 1'h0, link_l0_return = 1'h0, tlp_valid = 1'h0, err_valid = 1'h0;
    logic            tlp_secondary = 1'h0, err_from_tlp = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
    logic            s_axi_arvalid = 1'h0, s_axi_bready = 1'h1, s_axi_rready = 1'h1, aw_h, w_h, r_h, b_h;
    logic            s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, disp_valid;
    logic            err_msg_valid, sideband_wake_o, sideband_wake_oe, beacon_tx, wake_level;
    logic [1:0]      tlp_port = 2'h0, err_port = 2'h0, s_axi_bresp, s_axi_rresp, disp_port, err_msg_port, resp_q;
    logic [2:0]      hp_event = 3'h0, pme_tx, l1_permit;
    logic [2:0][1:0] power_state_field;
    logic [3:0]      s_axi_wstrb = 4'hF;
    logic [7:0]      pme_count_q;
    logic [11:0]     s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0]     s_axi_wdata = 32'h0, s_axi_rdata, rd_q;
    bpsc_kind_t      tlp_kind = K_CFG0;
    bpsc_disp_t      disp_code;
    int              mismatches = 0, total_checks = 0;
    bpsc_top u_bpsc_top (.*);
    bpsc_root_model u_bpsc_root_model (.*);
    always #2 sys_clk = ~sys_clk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // ready is looked at half a cycle early, so no race with the edge
    task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= {w, w, !w};
        do
        begin
            @(negedge sys_clk);
            {aw_h, w_h, r_h, b_h} = {s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid | s_axi_rvalid};
            {rd_q, resp_q} = {s_axi_rdata, s_axi_bvalid ? s_axi_bresp : s_axi_rresp};
            @(posedge sys_clk);
            s_axi_awvalid <= s_axi_awvalid & !aw_h;
            s_axi_wvalid <= s_axi_wvalid & !w_h;
            s_axi_arvalid <= s_axi_arvalid & !r_h;
        end
        while (!b_h);
        @(negedge sys_clk);
    endtask : acc
    task automatic ev(input logic [1:0] p, input bpsc_kind_t k, input logic s, input logic t,
                      input bpsc_disp_t e, input logic m);
        @(posedge sys_clk);
        {tlp_valid, err_valid, tlp_port, err_port, tlp_secondary, err_from_tlp} <= {2'h3, p, p, s, t};
        tlp_kind <= k;
        @(posedge sys_clk);
        {tlp_valid, err_valid} <= 2'h0;
        @(negedge sys_clk);
        chk({disp_valid, disp_port, disp_code, err_msg_valid, err_msg_port}, {1'h1, p, e, m, p});
    endtask : ev
    task automatic pulse(input logic [3:0] v);
        @(posedge sys_clk);
        {hp_event, turnoff_rx} <= v;
        @(posedge sys_clk);
        {hp_event, turnoff_rx} <= 4'h0;
        repeat (8) @(negedge sys_clk);
    endtask : pulse
    task automatic s_d3_entry;
        acc(1'h1, 12'h014, 32'h1);
        acc(1'h0, 12'h01C, 32'h0);
        chk(rd_q[1:0], 2'h1);
        acc(1'h1, 12'h010, 32'h0000_010B);
        chk({power_state_field[1], l1_permit}, {PS_FIELD_D3, 3'h2});
        acc(1'h0, 12'h040, 32'h0);
        chk(resp_q, RESP_SLVERR);
        ev(2'h1, K_CFG0, 1'h0, 1'h1, DISP_ACCEPT, 1'h1);
        ev(2'h1, K_MSG, 1'h0, 1'h0, DISP_ACCEPT, 1'h0);
        ev(2'h1, K_REQ, 1'h0, 1'h1, DISP_UR, 1'h1);
        ev(2'h1, K_CPL_OWN, 1'h0, 1'h0, DISP_UC, 1'h0);
        ev(2'h1, K_CPL_THRU, 1'h1, 1'h0, DISP_ROUTE, 1'h0);
        ev(2'h1, K_REQ, 1'h1, 1'h0, DISP_UR, 1'h0);
        ev(2'h2, K_REQ, 1'h0, 1'h0, DISP_ACCEPT, 1'h1);
    endtask : s_d3_entry
    task automatic s_upstream;
        acc(1'h1, 12'h004, 32'h1);
        acc(1'h1, 12'h008, 32'h0000_0020);
        chk(resp_q, RESP_OKAY);
        acc(1'h1, 12'h000, 32'h0000_010B);
        chk({power_state_field[0], l1_permit}, {PS_FIELD_D3, 3'h7});
        ev(2'h2, K_REQ, 1'h0, 1'h0, DISP_UR, 1'h0);
        acc(1'h1, 12'h000, 32'h0000_0108);
        chk({power_state_field[0], l1_permit}, {PS_FIELD_D0, 3'h2});
        acc(1'h0, 12'h008, 32'h0);
        chk(rd_q, 32'h0000_0020);
        acc(1'h0, 12'h030, 32'h0);
        chk(rd_q, 32'h0000_0003);
        @(posedge sys_clk);
        pwr_removed <= 1'h1;
        @(posedge sys_clk);
        pwr_removed <= 1'h0;
        acc(1'h0, 12'h01C, 32'h0);
        chk(rd_q[2:0], 3'h3);
        @(posedge sys_clk);
        rstn <= 1'h0;
        repeat (2) @(posedge sys_clk);
        rstn <= 1'h1;
        @(negedge sys_clk);
        chk({power_state_field[1], l1_permit}, {PS_FIELD_D0, 3'h0});
    endtask : s_upstream
    task automatic s_pme_wake;
        acc(1'h1, 12'h014, 32'h1);
        acc(1'h1, 12'h010, 32'h0000_010B);
        acc(1'h1, 12'h018, 32'h4);
        pulse(4'h4);
        chk(pme_count_q, 8'h01);
        repeat (1100) @(negedge sys_clk);
        chk(pme_count_q, 8'h02);
        acc(1'h1, 12'h010, 32'h0000_810B);
        repeat (1100) @(negedge sys_clk);
        chk(pme_count_q, 8'h02);
        pulse(4'h1);
        pulse(4'h4);
        chk(pme_count_q, 8'h02);
        @(posedge sys_clk);
        link_l0_return <= 1'h1;
        @(posedge sys_clk);
        link_l0_return <= 1'h0;
        repeat (8) @(negedge sys_clk);
        chk(pme_count_q, 8'h03);
        @(posedge sys_clk);
        l23_ready <= 1'h1;
        repeat (3) @(negedge sys_clk);
        chk({sideband_wake_oe, beacon_tx, wake_level, power_state_field[1]}, {3'h6, PS_FIELD_D0});
        chk(sideband_wake_o, 1'h0);
        acc(1'h0, 12'h010, 32'h0);
        chk(rd_q, 32'h0000_8008);
    endtask : s_pme_wake
    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : results
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        mismatches++;
        results();
    end
    initial
    begin
        repeat (3) @(posedge sys_clk);
        {rstn, aux_rstn} <= 2'h3;
        s_d3_entry();
        s_upstream();
        s_pme_wake();
        results();
    end
endmodule : bpsc_top_bench
